// ===== ufrx_cfg.svh
// Constants of the serial frame receiver: register map, field positions, reset values.
// Assumes an AXI4-Lite slave with 32-bit data and a 25 MHz core clock.
`ifndef UFRX_CFG_SVH
`define UFRX_CFG_SVH
`define UFRX_OFF_STATUS_A   8'h00
`define UFRX_OFF_CONTROL_B  8'h04
`define UFRX_OFF_CONTROL_C  8'h08
`define UFRX_OFF_DATA_PORT  8'h0C
`define UFRX_OFF_BAUD_DIV   8'h10
// Status A fields
`define UFRX_SA_PE          2
`define UFRX_SA_OVR         3
`define UFRX_SA_FE          4
`define UFRX_SA_RXC         7
// Control B fields
`define UFRX_CB_DATA8       0
`define UFRX_CB_RXEN        4
`define UFRX_CB_RXCIE       7
// Control C fields
`define UFRX_CC_SIZE_LO     1
`define UFRX_CC_STOP2       3
`define UFRX_CC_PODD        4
`define UFRX_CC_PON         5
// Reset values
`define UFRX_CB_RESET       8'h00
`define UFRX_CC_RESET       8'h06
`define UFRX_DIV_RESET      16'h000C
// Oversampling: sixteen ticks per bit, middle sample at tick 7
`define UFRX_OVS_LAST       4'hF
`define UFRX_OVS_MID        4'h7
`endif

// ===== ufrx_pkg.sv
// Types of the serial frame receiver.
// Assumes ufrx_cfg.svh provides all numeric constants.
package ufrx_pkg;
    typedef enum logic [2:0] {UFRX_IDLE, UFRX_START, UFRX_DATA, UFRX_PAR, UFRX_STOP} ufrx_state_t;
    typedef struct packed {
        logic [8:0] data;
        logic       fe;
        logic       pe;
        logic       ovr;
    } ufrx_entry_t;
endpackage

// ===== ufrx_top.sv
// Asynchronous serial receiver with two-entry buffer, error flags and AXI4-Lite registers.
// Assumes rx_line is already synchronous to core_clk; one clock, synchronous reset.
`timescale 1ns/10ps
`include "ufrx_cfg.svh"

// Operation
// - Accept all thirty start/data/parity/stop layouts
// - Start bit, then data LSB first
// - Parity bit follows last data bit
// - Next start may follow stop directly
// - Complete flag set while buffer holds data
// - Receiver disable flushes the buffer
// - Interrupt level equals enable and flag
// - Data read pops the oldest character
// - Error flags stored per buffered character
// - Writes to status A never alter error flags
// - Error flags raise no interrupt
// - Frame error reflects first stop bit
// - Only first stop bit is checked
// - Overrun when buffer full, shifter full, start
// - Overrun clears on successful buffer transfer
// - Parity error zero while checking off
// - Upper bit enables, lower selects odd
// - Parity computed and stored with character
module ufrx_top #(
    parameter int DEPTH = 2   // Receive buffer entries
) (
    input  wire logic        core_clk,       // System clock, 25 MHz
    input  wire logic        sys_rst,        // Synchronous reset, active high
    input  wire logic        rx_line,        // Serial receive line, idle high
    output logic             rx_irq,         // Receive-complete interrupt level
    input  wire logic [7:0]  s_axi_awaddr,   // Write address
    input  wire logic        s_axi_awvalid,  // Write address valid
    output logic             s_axi_awready,  // Write address ready
    input  wire logic [31:0] s_axi_wdata,    // Write data
    input  wire logic [3:0]  s_axi_wstrb,    // Write byte strobes
    input  wire logic        s_axi_wvalid,   // Write data valid
    output logic             s_axi_wready,   // Write data ready
    output logic [1:0]       s_axi_bresp,    // Write response
    output logic             s_axi_bvalid,   // Write response valid
    input  wire logic        s_axi_bready,   // Write response ready
    input  wire logic [7:0]  s_axi_araddr,   // Read address
    input  wire logic        s_axi_arvalid,  // Read address valid
    output logic             s_axi_arready,  // Read address ready
    output logic [31:0]      s_axi_rdata,    // Read data
    output logic [1:0]       s_axi_rresp,    // Read response
    output logic             s_axi_rvalid,   // Read response valid
    input  wire logic        s_axi_rready    // Read response ready
);

    // Even parity over the enabled data bits
    function automatic logic even_parity(input logic [8:0] d, input logic [3:0] n);
        logic p;
        p = 1'b0;
        for (int i = 0; i < 9; i++)
        begin
            if (i < int'(n))
            begin
                p = p ^ d[i];
            end
        end
        return p;
    endfunction

    logic [7:0]                ctrl_b_ff, ctrl_c_ff, aw_addr_ff;
    logic [15:0]               div_ff, div_cnt_ff;
    logic [31:0]               w_data_ff;
    logic [8:0]                shift_ff;
    logic [3:0]                ovs_ff, bit_cnt_ff, data_bits, w_strb_ff;
    logic [1:0]                count_ff;
    ufrx_pkg::ufrx_state_t     state_ff;
    ufrx_pkg::ufrx_entry_t     hold_entry_ff, head;
    ufrx_pkg::ufrx_entry_t     buf_ff [DEPTH];
    logic                      tick, par_bit_ff, rx_prev_ff, hold_ff, rd_ptr_ff, wr_ptr_ff, ovr_pend_ff;
    logic                      receiver_enable, rx_complete_irq_enable, parity_check_on, parity_odd_select;
    logic                      rx_complete_flag, frame_done, push, pop, start_seen, aw_hold_ff, w_hold_ff;
    logic                      do_write, do_read;

    // Configuration fields
    assign receiver_enable        = ctrl_b_ff[`UFRX_CB_RXEN];
    assign rx_complete_irq_enable = ctrl_b_ff[`UFRX_CB_RXCIE];
    assign parity_check_on        = ctrl_c_ff[`UFRX_CC_PON];
    assign parity_odd_select      = ctrl_c_ff[`UFRX_CC_PODD];
    assign data_bits = ctrl_b_ff[`UFRX_CB_DATA8] ? 4'd9
                     : 4'd5 + {2'b00, ctrl_c_ff[`UFRX_CC_SIZE_LO +: 2]};
    assign head             = buf_ff[rd_ptr_ff];
    assign rx_complete_flag = receiver_enable && (count_ff != 2'h0);
    assign rx_irq           = rx_complete_irq_enable & rx_complete_flag;

    // Baud tick divider, sixteen ticks per bit
    always_ff @(posedge core_clk)
    begin
        if (sys_rst || div_cnt_ff == 16'h0000)
            div_cnt_ff <= div_ff;
        else
            div_cnt_ff <= div_cnt_ff - 16'h0001;
    end
    assign tick = (div_cnt_ff == 16'h0000);

    // Line edge detection for start bits
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            rx_prev_ff <= 1'b1;
        else
            rx_prev_ff <= rx_line;
    end
    assign start_seen = receiver_enable && state_ff == ufrx_pkg::UFRX_IDLE
                        && rx_prev_ff && !rx_line;

    // Frame receive state machine
    always_ff @(posedge core_clk)
    begin
        if (sys_rst || !receiver_enable)
        begin
            state_ff   <= ufrx_pkg::UFRX_IDLE;
            ovs_ff     <= 4'h0;
            bit_cnt_ff <= 4'h0;
            shift_ff   <= 9'h000;
            par_bit_ff <= 1'b0;
        end
        else
        begin
            case (state_ff)
                ufrx_pkg::UFRX_IDLE:
                begin
                    ovs_ff <= 4'h0;
                    if (start_seen)
                    begin
                        state_ff <= ufrx_pkg::UFRX_START;
                    end
                end
                ufrx_pkg::UFRX_START:
                begin
                    if (tick)
                    begin
                        ovs_ff <= ovs_ff + 4'h1;
                        if (ovs_ff == `UFRX_OVS_MID && rx_line)
                        begin
                            state_ff <= ufrx_pkg::UFRX_IDLE;   // False start
                        end
                        else if (ovs_ff == `UFRX_OVS_LAST)
                        begin
                            state_ff   <= ufrx_pkg::UFRX_DATA;
                            bit_cnt_ff <= 4'h0;
                            shift_ff   <= 9'h000;
                        end
                    end
                end
                ufrx_pkg::UFRX_DATA:
                begin
                    if (tick)
                    begin
                        ovs_ff <= ovs_ff + 4'h1;
                        if (ovs_ff == `UFRX_OVS_MID)
                        begin
                            shift_ff[bit_cnt_ff] <= rx_line;
                        end
                        if (ovs_ff == `UFRX_OVS_LAST)
                        begin
                            bit_cnt_ff <= bit_cnt_ff + 4'h1;
                            if (bit_cnt_ff + 4'h1 == data_bits)
                            begin
                                state_ff <= parity_check_on ? ufrx_pkg::UFRX_PAR
                                                            : ufrx_pkg::UFRX_STOP;
                            end
                        end
                    end
                end
                ufrx_pkg::UFRX_PAR:
                begin
                    if (tick)
                    begin
                        ovs_ff <= ovs_ff + 4'h1;
                        if (ovs_ff == `UFRX_OVS_MID)
                        begin
                            par_bit_ff <= rx_line;
                        end
                        if (ovs_ff == `UFRX_OVS_LAST)
                        begin
                            state_ff <= ufrx_pkg::UFRX_STOP;
                        end
                    end
                end
                ufrx_pkg::UFRX_STOP:
                begin
                    if (tick)
                    begin
                        ovs_ff <= ovs_ff + 4'h1;
                        if (ovs_ff == `UFRX_OVS_MID)
                        begin
                            state_ff <= ufrx_pkg::UFRX_IDLE;   // Only first stop bit
                        end
                    end
                end
                default:
                begin
                    state_ff <= ufrx_pkg::UFRX_IDLE;
                end
            endcase
        end
    end
    assign frame_done = receiver_enable && tick && state_ff == ufrx_pkg::UFRX_STOP
                        && ovs_ff == `UFRX_OVS_MID;

    // Shift-register holding stage with frame status
    always_ff @(posedge core_clk)
    begin
        if (sys_rst || !receiver_enable)
        begin
            hold_ff       <= 1'b0;
            hold_entry_ff <= '0;
        end
        else if (frame_done)
        begin
            hold_ff            <= 1'b1;
            hold_entry_ff.data <= shift_ff;
            hold_entry_ff.fe   <= !rx_line;
            hold_entry_ff.pe   <= parity_check_on &&
                (even_parity(shift_ff, data_bits) ^ parity_odd_select ^ par_bit_ff);
            hold_entry_ff.ovr  <= 1'b0;
        end
        else if (push)
            hold_ff <= 1'b0;
    end
    assign push = hold_ff && (count_ff < 2'(DEPTH) || pop);

    // Overrun detection: buffer full, shifter waiting, new start
    always_ff @(posedge core_clk)
    begin
        if (sys_rst || !receiver_enable)
            ovr_pend_ff <= 1'b0;
        else if (hold_ff && count_ff == 2'(DEPTH) && !pop && start_seen)
            ovr_pend_ff <= 1'b1;
        else if (push)
            ovr_pend_ff <= 1'b0;
    end

    // Two-entry receive buffer with per-character flags
    always_ff @(posedge core_clk)
    begin
        if (sys_rst || !receiver_enable)
        begin
            rd_ptr_ff <= 1'b0;
            wr_ptr_ff <= 1'b0;
            count_ff  <= 2'd0;
            for (int i = 0; i < DEPTH; i++)
                buf_ff[i] <= '0;
        end
        else
        begin
            if (push)
            begin
                buf_ff[wr_ptr_ff]     <= hold_entry_ff;
                buf_ff[wr_ptr_ff].ovr <= ovr_pend_ff;
                wr_ptr_ff             <= ~wr_ptr_ff;
            end
            if (pop)
                rd_ptr_ff <= ~rd_ptr_ff;
            count_ff <= count_ff + {1'b0, push} - {1'b0, pop};
        end
    end

    // AXI write channel capture
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            aw_hold_ff <= 1'b0;
            w_hold_ff  <= 1'b0;
            aw_addr_ff <= 8'h00;
            w_data_ff  <= 32'h0000_0000;
            w_strb_ff  <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_ff <= 1'b1;
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_hold_ff <= 1'b0;
                w_hold_ff  <= 1'b0;
            end
        end
    end
    assign s_axi_awready = !aw_hold_ff && !s_axi_bvalid;
    assign s_axi_wready  = !w_hold_ff && !s_axi_bvalid;
    assign do_write      = aw_hold_ff && w_hold_ff && !s_axi_bvalid;

    // Register writes; status A flags are read-only
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            ctrl_b_ff <= `UFRX_CB_RESET;
            ctrl_c_ff <= `UFRX_CC_RESET;
            div_ff    <= `UFRX_DIV_RESET;
        end
        else if (do_write)
        begin
            if (aw_addr_ff[7:2] == `UFRX_OFF_CONTROL_B >> 2 && w_strb_ff[0])
                ctrl_b_ff <= w_data_ff[7:0];
            else if (aw_addr_ff[7:2] == `UFRX_OFF_CONTROL_C >> 2 && w_strb_ff[0])
                ctrl_c_ff <= w_data_ff[7:0];
            else if (aw_addr_ff[7:2] == `UFRX_OFF_BAUD_DIV >> 2)
            begin
                if (w_strb_ff[0])
                    div_ff[7:0] <= w_data_ff[7:0];
                if (w_strb_ff[1])
                    div_ff[15:8] <= w_data_ff[15:8];
            end
        end
    end
    // Writes to status A are accepted and discarded

    // Write response
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_ff[7:2] <= `UFRX_OFF_BAUD_DIV >> 2) ? 2'b00 : 2'b10;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // Read channel; a data-port read pops the buffer
    assign s_axi_arready = !s_axi_rvalid;
    assign do_read       = s_axi_arvalid && s_axi_arready;
    assign pop = do_read && s_axi_araddr[7:2] == `UFRX_OFF_DATA_PORT >> 2 && count_ff != 2'd0;
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'b00;
        end
        else if (do_read)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'b00;
            s_axi_rdata  <= 32'h0000_0000;
            if (s_axi_araddr[7:2] == `UFRX_OFF_STATUS_A >> 2)
            begin
                s_axi_rdata[`UFRX_SA_RXC] <= rx_complete_flag;
                s_axi_rdata[`UFRX_SA_FE]  <= rx_complete_flag & head.fe;
                s_axi_rdata[`UFRX_SA_OVR] <= rx_complete_flag & head.ovr;
                s_axi_rdata[`UFRX_SA_PE]  <= rx_complete_flag & parity_check_on & head.pe;
            end
            else if (s_axi_araddr[7:2] == `UFRX_OFF_CONTROL_B >> 2)
                s_axi_rdata[7:0] <= ctrl_b_ff;
            else if (s_axi_araddr[7:2] == `UFRX_OFF_CONTROL_C >> 2)
                s_axi_rdata[7:0] <= ctrl_c_ff;
            else if (s_axi_araddr[7:2] == `UFRX_OFF_DATA_PORT >> 2)
                s_axi_rdata[8:0] <= rx_complete_flag ? head.data : 9'h000;
            else if (s_axi_araddr[7:2] == `UFRX_OFF_BAUD_DIV >> 2)
                s_axi_rdata[15:0] <= div_ff;
            else
                s_axi_rresp <= 2'b10;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

endmodule

// ===== ufrx_line_tx.sv
// Model of the remote serial transmitter that drives the receive line.
// Assumes a baud divider of zero in the receiver, so one bit lasts 16 clocks.
`timescale 1ns/10ps
module ufrx_line_tx #(
    parameter int BIT_CLKS = 16   // Clocks per bit
) (
    input  wire logic core_clk,   // Clock the bit timing counts on
    output logic      rx_line     // Serial line into the receiver
);
    // Line rests high between frames
    initial rx_line = 1'b1;

    // One bit held for a whole bit time
    task automatic put_bit(input logic b);
        @(posedge core_clk);
        rx_line <= b;
        repeat (BIT_CLKS - 1) @(posedge core_clk);
    endtask

    // One frame after gap idle clocks; bad_stop and bad_par corrupt it on purpose
    task automatic send(input logic [8:0] d, input int nb, input logic pon, input logic podd,
                        input logic stop2, input logic bad_stop, input logic bad_par, input int gap);
        logic p;
        p = podd;
        repeat (gap) @(posedge core_clk);
        put_bit(1'b0);
        for (int i = 0; i < nb; i++)
        begin
            put_bit(d[i]);
            p = p ^ d[i];
        end
        if (pon)
            put_bit(p ^ bad_par);
        put_bit(!bad_stop);
        if (stop2 || bad_stop)
            put_bit(1'b1);
    endtask
endmodule

// ===== ufrx_asserts.sv
// Checker for the serial receiver: bus answers, interrupt level, status bits.
// Assumes it is bound to ufrx_top and that writes are answered one at a time.
`timescale 1ns/10ps
`include "ufrx_cfg.svh"
module ufrx_asserts #(
    parameter int DEPTH = 2   // Receive buffer entries
) (
    input wire logic        core_clk,       // Clock
    input wire logic        sys_rst,        // Synchronous reset
    input wire logic        rx_irq,         // Interrupt level
    input wire logic [7:0]  s_axi_awaddr,   // Write address
    input wire logic        s_axi_awvalid,  // Write address valid
    input wire logic        s_axi_awready,  // Write address ready
    input wire logic [31:0] s_axi_wdata,    // Write data
    input wire logic [3:0]  s_axi_wstrb,    // Write strobes
    input wire logic        s_axi_wvalid,   // Write data valid
    input wire logic        s_axi_wready,   // Write data ready
    input wire logic [1:0]  s_axi_bresp,    // Write response
    input wire logic        s_axi_bvalid,   // Write response valid
    input wire logic        s_axi_bready,   // Write response ready
    input wire logic [7:0]  s_axi_araddr,   // Read address
    input wire logic        s_axi_arvalid,  // Read address valid
    input wire logic        s_axi_arready,  // Read address ready
    input wire logic [31:0] s_axi_rdata,    // Read data
    input wire logic        s_axi_rvalid,   // Read data valid
    input wire logic        s_axi_rready    // Read data ready
);
    logic [7:0]  wa_q;
    logic [31:0] wd_q;
    logic        ws_q;
    logic        bv_q;
    logic        ie_q;
    logic        en_q;
    logic        pon_q;
    logic        commit;
    logic        ie_now;
    logic        en_now;
    logic        pon_now;

    // Capture the write that is being answered
    always_ff @(posedge core_clk)
    begin
        if (s_axi_awvalid && s_axi_awready)
            wa_q <= s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready)
        begin
            wd_q <= s_axi_wdata;
            ws_q <= s_axi_wstrb[0];
        end
    end

    // Control bits as they stand once a write is answered
    assign commit  = s_axi_bvalid && !bv_q && ws_q && (s_axi_bresp == 2'b00);
    assign ie_now  = (commit && wa_q == `UFRX_OFF_CONTROL_B) ? wd_q[`UFRX_CB_RXCIE] : ie_q;
    assign en_now  = (commit && wa_q == `UFRX_OFF_CONTROL_B) ? wd_q[`UFRX_CB_RXEN] : en_q;
    assign pon_now = (commit && wa_q == `UFRX_OFF_CONTROL_C) ? wd_q[`UFRX_CC_PON] : pon_q;

    // Shadow of the control bits, cleared like the registers
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            bv_q  <= 1'b0;
            ie_q  <= 1'b0;
            en_q  <= 1'b0;
            pon_q <= 1'b0;
        end
        else
        begin
            bv_q  <= s_axi_bvalid;
            ie_q  <= ie_now;
            en_q  <= en_now;
            pon_q <= pon_now;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_status;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == `UFRX_OFF_STATUS_A;
    endsequence

    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    read_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer kept after being taken");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    write_answer_a: assert property (wr_both |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    irq_gate_a: assert property (!(ie_now && en_now) |-> !rx_irq)
        else $error("interrupt high while disabled");
    flag_irq_a: assert property (rd_status ##0 ie_now ##1 1'b1 |-> s_axi_rdata[`UFRX_SA_RXC] == $past(rx_irq))
        else $error("complete flag differs from interrupt");
    parity_off_a: assert property (rd_status ##0 !pon_now |=> !s_axi_rdata[`UFRX_SA_PE])
        else $error("parity error shown while checking off");
endmodule

bind ufrx_top ufrx_asserts #(.DEPTH(DEPTH)) u_asserts (.core_clk, .sys_rst, .rx_irq, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

// ===== uart_frame_rx_status_tb.sv
// Self-checking bench for the serial receiver and its register bus.
// Assumes the baud divider is written to zero, so a bit lasts 16 clocks.
`timescale 1ns/10ps
`include "ufrx_cfg.svh"
module uart_frame_rx_status_tb;
    logic        core_clk, sys_rst, rx_line, rx_irq;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, v;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int          n_mismatch = 0;
    int          checked = 0;

    // 25 MHz clock
    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    ufrx_top uut (.core_clk, .sys_rst, .rx_line, .rx_irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    ufrx_line_tx uline (.core_clk, .rx_line);

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Write with both halves offered together; response code lands in r
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge core_clk);
            n++;
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid && n < 200);
        chk("write answer", 32'h1, 32'(s_axi_bvalid));
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    // Read; data lands in v and response code in r
    task automatic axi_read(input logic [7:0] a);
        int n = 0;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge core_clk);
            n++;
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid && n < 200);
        chk("read answer", 32'h1, 32'(s_axi_rvalid));
        v = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input string name);
        axi_read(a);
        chk(name, e, v & m);
    endtask

    // Configure, receive one frame, then check status, flags and data
    task automatic rx_case(input int nb, input logic pon, input logic podd, input logic stop2,
                           input logic bad_stop, input logic bad_par, input logic [7:0] st);
        logic [8:0] d;
        logic [1:0] sz;
        int n = 0;
        d = (9'h1B5 ^ 9'(nb * 37)) & (9'h1FF >> (9 - nb));
        sz = (nb == 9) ? 2'b11 : 2'(nb - 5);
        axi_write(`UFRX_OFF_CONTROL_C, {26'h0, pon, podd, stop2, sz, 1'b0});
        axi_write(`UFRX_OFF_CONTROL_B, {24'h0, 7'h48, nb == 9});
        uline.send(d, nb, pon, podd, stop2, bad_stop, bad_par, 2);
        while (!rx_irq && n < 400)
        begin
            @(posedge core_clk);
            n++;
        end
        chk("irq", 32'h1, 32'(rx_irq));
        rd_chk(`UFRX_OFF_STATUS_A, 32'(st), 32'h9C, "status");
        axi_write(`UFRX_OFF_STATUS_A, 32'h0);
        rd_chk(`UFRX_OFF_STATUS_A, 32'(st), 32'h9C, "status kept");
        rd_chk(`UFRX_OFF_DATA_PORT, 32'(d), 32'h1FF, "data");
        chk("irq", 32'h0, 32'(rx_irq));
    endtask

    // Watchdog far beyond the expected run
    initial
    begin
        repeat (60000) @(posedge core_clk);
        n_mismatch++;
        conclude();
    end

    // Main sequence
    initial
    begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr} = 16'h0000;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hF;
        sys_rst = 1'b1;
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd_chk(`UFRX_OFF_CONTROL_B, 32'h00, 32'hFF, "control_b");
        rd_chk(`UFRX_OFF_CONTROL_C, 32'h06, 32'hFF, "control_c");
        rd_chk(`UFRX_OFF_BAUD_DIV, 32'h0C, 32'hFFFF, "baud_div");
        chk("read response", 32'h0, 32'(r));
        axi_read(8'h14);
        chk("unmapped read", 32'h2, 32'(r));
        axi_write(8'h14, 32'h0);
        chk("unmapped write", 32'h2, 32'(r));
        axi_write(`UFRX_OFF_BAUD_DIV, 32'h0);
        // Every size, parity mode and stop count
        for (int nb = 5; nb <= 9; nb++)
            for (int pm = 0; pm < 3; pm++)
                for (int s = 0; s < 2; s++)
                    rx_case(nb, pm != 0, pm == 2, s[0], 1'b0, 1'b0, 8'h80);
        rx_case(8, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 8'h84);
        rx_case(7, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 8'h90);
        rx_case(5, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 8'h90);
        // Four frames back to back with nothing read
        axi_write(`UFRX_OFF_CONTROL_C, 32'h06);
        axi_write(`UFRX_OFF_CONTROL_B, 32'h90);
        for (int k = 1; k <= 4; k++)
            uline.send(9'(k * 17), 8, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 0);
        repeat (40) @(posedge core_clk);
        rd_chk(`UFRX_OFF_STATUS_A, 32'h80, 32'h9C, "status");
        rd_chk(`UFRX_OFF_DATA_PORT, 32'h11, 32'h1FF, "data");
        rd_chk(`UFRX_OFF_STATUS_A, 32'h80, 32'h9C, "status");
        rd_chk(`UFRX_OFF_DATA_PORT, 32'h22, 32'h1FF, "data");
        rd_chk(`UFRX_OFF_STATUS_A, 32'h88, 32'h9C, "status");
        uline.send(9'h055, 8, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 0);
        rd_chk(`UFRX_OFF_DATA_PORT, 32'h44, 32'h1FF, "data");
        rd_chk(`UFRX_OFF_STATUS_A, 32'h80, 32'h9C, "status");
        axi_write(`UFRX_OFF_CONTROL_B, 32'h10);
        chk("irq", 32'h0, 32'(rx_irq));
        rd_chk(`UFRX_OFF_STATUS_A, 32'h80, 32'h9C, "status");
        axi_write(`UFRX_OFF_CONTROL_B, 32'h00);
        rd_chk(`UFRX_OFF_STATUS_A, 32'h00, 32'h9C, "status");
        rx_case(8, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h80);
        conclude();
    end
endmodule
